// ==== rtl/flash_bus_cycle.sv ====
`include "flash_status_defs.svh"
`default_nettype none
// one read or write cycle on the parallel flash pins
module flash_bus_cycle (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // request
  input wire logic start,
  input wire logic write,
  input wire logic [21:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // pins
  output logic [21:0] flash_addr,
  output logic chip_select_n,
  output logic output_strobe_n,
  output logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_STROBE = 2'h3,
    PH_HOLD = 2'h2
  } phase_t;
  phase_t phase;
  logic [3:0] count;
  logic is_write;
  logic [7:0] data_meta;
  logic [7:0] data_sync;

  // pins are asynchronous to our clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= PH_IDLE;
      count <= 4'h0;
      is_write <= 1'b0;
      flash_addr <= 22'h000000;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      chip_select_n <= 1'b1;
      output_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      rdata <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (phase)
        PH_IDLE: begin
          if (start) begin
            phase <= PH_SETUP;
            count <= `BUS_SETUP_CYC;
            is_write <= write;
            flash_addr <= addr;
            data_out <= wdata;
            data_oe <= write;
            chip_select_n <= 1'b0;
          end
        end
        PH_SETUP: begin
          if (count == 4'h1) begin
            phase <= PH_STROBE;
            count <= `BUS_STROBE_CYC;
            write_strobe_n <= ~is_write;
            output_strobe_n <= is_write;
          end else begin
            count <= count - 4'h1;
          end
        end
        PH_STROBE: begin
          // extra margin covers the two-flop input delay
          if (count == 4'h1) begin
            phase <= PH_HOLD;
            count <= `BUS_HOLD_CYC;
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
          end else begin
            count <= count - 4'h1;
          end
        end
        PH_HOLD: begin
          if (count == `BUS_HOLD_CYC && !is_write) begin
            rdata <= data_sync;
          end
          if (count == 4'h1) begin
            phase <= PH_IDLE;
            chip_select_n <= 1'b1;
            data_oe <= 1'b0;
            done <= 1'b1;
          end else begin
            count <= count - 4'h1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/flash_status_defs.svh ====
`ifndef FLASH_STATUS_DEFS_SVH
`define FLASH_STATUS_DEFS_SVH
// Function
// - Mode comes from toggle_bit_one and sector from toggle_bit_two; the host combines both.
// - The host starts a check with two reads in a row; an unchanged toggle means done.
// - If still toggling with timing_limit_flag high, the host rechecks; toggling then means failure and a reset command.
// - A host that leaves polling restarts from the first double read.
// - After any timing-limit failure the host writes the reset command.
// - The host may ignore erase_window_flag only if command gaps stay under 50 us.
// - The host confirms a sector erase by toggle_bit_one, then checks erase_window_flag around each added one.
// - Status reads use the program address or an address in an erasing sector.

// bus timing, in cycles of the 25 ns clock
`define BUS_SETUP_CYC 4'h2
`define BUS_STROBE_CYC 4'h4
`define BUS_HOLD_CYC 4'h2
`define CLK_NS 25
`define GAP_LIMIT_NS 50000
// gap bound for erase commands chained without flag checks; unused, the host reads the flag before each added sector
`define GAP_CYC ((`GAP_LIMIT_NS / `CLK_NS) - 1)
`define GAP_W 11

// status bit positions
`define BIT_DATA_POLL 7
`define BIT_TOGGLE_ONE 6
`define BIT_TIME_LIMIT 5
`define BIT_ERASE_WIN 3
`define BIT_TOGGLE_TWO 2

// command bytes and addresses
`define ADDR_UNLOCK1 22'h000555
`define ADDR_UNLOCK2 22'h0002AA
`define DATA_UNLOCK1 8'hAA
`define DATA_UNLOCK2 8'h55
`define DATA_ERASE_SETUP 8'h80
`define DATA_SECTOR_ERASE 8'h30
`define DATA_PROGRAM 8'hA0
`define DATA_RESET 8'hF0
`define DATA_SUSPEND 8'hB0
`define DATA_RESUME 8'h30
`endif

// ==== rtl/flash_status_host.sv ====
`include "flash_status_defs.svh"
`default_nettype none
// host sequencer: issues program, sector erase, added sector erase and
// suspend, then polls status with the toggle procedure, or reads the window flag after an added sector
module flash_status_host (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // user orders
  input wire logic op_valid,
  input wire flash_status_pkg::op_t op_kind,
  input wire logic [21:0] op_addr,
  input wire logic [7:0] op_data,
  output logic op_ready,
  output logic result_valid,
  output flash_status_pkg::result_t result_code,
  output logic erase_started,
  output logic sector_erasing,
  output logic [7:0] last_status,
  // flash pins
  output logic [21:0] flash_addr,
  output logic chip_select_n,
  output logic output_strobe_n,
  output logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic ready_busy_out
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD = 4'h1,
    ST_WIN_PRE = 4'h3,
    ST_READ1 = 4'h2,
    ST_READ2 = 4'h6,
    ST_READ3 = 4'h7,
    ST_WIN_POST = 4'h5,
    ST_RESET = 4'h4,
    ST_REPORT = 4'hC
  } state_t;
  state_t state;
  flash_status_pkg::op_t kind;
  logic [21:0] target;
  logic [7:0] payload;
  logic [2:0] step;
  logic [2:0] steps;
  logic [7:0] first_read;
  logic rb_meta;
  logic rb_sync;
  logic bus_start;
  logic bus_write;
  logic [21:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_done;
  logic [7:0] bus_rdata;

  // write cycles of each command
  function automatic logic [2:0] cmd_len(flash_status_pkg::op_t k);
    unique case (k)
      flash_status_pkg::OP_PROGRAM: cmd_len = 3'h4;
      flash_status_pkg::OP_SECTOR_ERASE: cmd_len = 3'h6;
      flash_status_pkg::OP_ADD_SECTOR: cmd_len = 3'h1;
      flash_status_pkg::OP_SUSPEND: cmd_len = 3'h1;
    endcase
  endfunction

  function automatic logic [29:0] cmd_word(flash_status_pkg::op_t k,
      logic [2:0] i, logic [21:0] a, logic [7:0] d);
    logic [29:0] w;
    w = {a, d};
    if (k == flash_status_pkg::OP_SUSPEND) begin
      w = {a, `DATA_SUSPEND};
    end else if (k == flash_status_pkg::OP_ADD_SECTOR) begin
      w = {a, `DATA_SECTOR_ERASE};
    end else if (i == 3'h0 || i == 3'h3) begin
      w = (k == flash_status_pkg::OP_PROGRAM && i == 3'h3) ? {a, d} :
          {`ADDR_UNLOCK1, `DATA_UNLOCK1};
    end else if (i == 3'h1 || i == 3'h4) begin
      w = {`ADDR_UNLOCK2, `DATA_UNLOCK2};
    end else if (i == 3'h2) begin
      w = {`ADDR_UNLOCK1, (k == flash_status_pkg::OP_PROGRAM) ?
           `DATA_PROGRAM : `DATA_ERASE_SETUP};
    end else begin
      w = {a, `DATA_SECTOR_ERASE};
    end
    return w;
  endfunction

  function automatic logic toggled(logic [7:0] x, logic [7:0] y, int b);
    return x[b] != y[b];
  endfunction

  flash_bus_cycle bus (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(bus_start),
    .write(bus_write),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .chip_select_n(chip_select_n),
    .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe)
  );

  // busy pin from the device
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      rb_meta <= ready_busy_out;
      rb_sync <= rb_meta;
    end
  end

  assign op_ready = (state == ST_IDLE);

  // status reads go to the target address: program or erasing sector
  always_comb begin
    bus_write = (state == ST_CMD) || (state == ST_RESET);
    bus_addr = target;
    bus_wdata = 8'h00;
    if (state == ST_CMD) begin
      {bus_addr, bus_wdata} = cmd_word(kind, step, target, payload);
    end else if (state == ST_RESET) begin
      bus_wdata = `DATA_RESET;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      kind <= flash_status_pkg::OP_PROGRAM;
      target <= 22'h000000;
      payload <= 8'h00;
      step <= 3'h0;
      steps <= 3'h0;
      first_read <= 8'h00;
      bus_start <= 1'b0;
      result_valid <= 1'b0;
      result_code <= flash_status_pkg::RESULT_DONE;
      last_status <= 8'h00;
      erase_started <= 1'b0;
      sector_erasing <= 1'b0;
    end else begin
      bus_start <= 1'b0;
      result_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (op_valid) begin
            kind <= op_kind;
            target <= op_addr;
            payload <= op_data;
            step <= 3'h0;
            steps <= cmd_len(op_kind);
            bus_start <= 1'b1;
            // check the window flag before an added sector
            state <= (op_kind == flash_status_pkg::OP_ADD_SECTOR) ?
                     ST_WIN_PRE : ST_CMD;
          end
        end
        ST_WIN_PRE: begin
          if (bus_done) begin
            last_status <= bus_rdata;
            erase_started <= bus_rdata[`BIT_ERASE_WIN];
            // flag read before every added sector, so gaps need no bound
            if (bus_rdata[`BIT_ERASE_WIN]) begin
              // erasing already: added sectors would be ignored
              result_code <= flash_status_pkg::RESULT_REJECTED;
              state <= ST_REPORT;
            end else begin
              bus_start <= 1'b1;
              state <= ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (bus_done) begin
            bus_start <= 1'b1;
            if (step == steps - 3'h1) begin
              state <= (kind == flash_status_pkg::OP_ADD_SECTOR) ?
                       ST_WIN_POST : ST_READ1;
            end else begin
              step <= step + 3'h1;
            end
          end
        end
        ST_WIN_POST: begin
          if (bus_done) begin
            last_status <= bus_rdata;
            erase_started <= bus_rdata[`BIT_ERASE_WIN];
            result_code <= bus_rdata[`BIT_ERASE_WIN] ?
                flash_status_pkg::RESULT_REJECTED :
                flash_status_pkg::RESULT_DONE;
            state <= ST_REPORT;
          end
        end
        // every poll starts with a fresh pair of reads
        ST_READ1: begin
          if (bus_done) begin
            first_read <= bus_rdata;
            bus_start <= 1'b1;
            state <= ST_READ2;
          end
        end
        ST_READ2: begin
          if (bus_done) begin
            last_status <= bus_rdata;
            erase_started <= bus_rdata[`BIT_ERASE_WIN];
            // a stopped pair may straddle status and array data, so
            // toggle two only counts while erasing or suspended
            sector_erasing <= toggled(first_read, bus_rdata,
                `BIT_TOGGLE_TWO) &&
                (kind == flash_status_pkg::OP_SUSPEND ||
                toggled(first_read, bus_rdata, `BIT_TOGGLE_ONE));
            if (!toggled(first_read, bus_rdata, `BIT_TOGGLE_ONE)) begin
              // stopped: done, or suspended when the order was a suspend
              result_code <= (kind == flash_status_pkg::OP_SUSPEND) ?
                  flash_status_pkg::RESULT_SUSPENDED :
                  flash_status_pkg::RESULT_DONE;
              state <= ST_REPORT;
            end else if (bus_rdata[`BIT_TIME_LIMIT]) begin
              first_read <= bus_rdata;
              bus_start <= 1'b1;
              state <= ST_READ3;
            end else begin
              bus_start <= 1'b1;
              state <= ST_READ1;
            end
          end
        end
        ST_READ3: begin
          if (bus_done) begin
            last_status <= bus_rdata;
            if (toggled(first_read, bus_rdata, `BIT_TOGGLE_ONE)) begin
              result_code <= flash_status_pkg::RESULT_FAIL;
              bus_start <= 1'b1;
              state <= ST_RESET;
            end else begin
              result_code <= flash_status_pkg::RESULT_DONE;
              state <= ST_REPORT;
            end
          end
        end
        ST_RESET: begin
          if (bus_done) begin
            state <= ST_REPORT;
          end
        end
        ST_REPORT: begin
          // device must be idle or suspended before the next order, unless the order was rejected
          if (rb_sync || result_code ==
              flash_status_pkg::RESULT_REJECTED) begin
            result_valid <= 1'b1;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/flash_status_pkg.sv ====
`default_nettype none
package flash_status_pkg;
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_SECTOR_ERASE = 2'h1,
    OP_ADD_SECTOR = 2'h2,
    OP_SUSPEND = 2'h3
  } op_t;
  typedef enum logic [1:0] {
    RESULT_DONE = 2'h0,
    RESULT_FAIL = 2'h1,
    RESULT_REJECTED = 2'h2,
    RESULT_SUSPENDED = 2'h3
  } result_t;
endpackage
`default_nettype wire

// ==== verif/flash_dev_model.sv ====
`include "flash_status_defs.svh"
`default_nettype none
// time is counted in read strobes, so polling length sets every delay
module flash_dev_model #(
  parameter int WIN_RD = 4,
  parameter int OP_RD = 5
) (
  // pins
  input wire logic [21:0] flash_addr,
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  output logic [7:0] data_in,
  output logic ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // 0 read, 1 program, 2 window, 3 erase, 4 suspended
  int mode = 0;
  int step = 0;
  int cnt = 0;
  logic t1 = 1'b0, t2 = 1'b0, tl = 1'b0, bad = 1'b0;
  logic [3:0] pa = 4'h0;
  logic [7:0] pd = 8'hFF, last = 8'h00;
  logic [7:0] mem [16];
  logic [63:0] es = 64'h0;
  wire rd = !chip_select_n && !output_strobe_n;
  wire wr = !chip_select_n && !write_strobe_n;
  wire u1 = flash_addr == `ADDR_UNLOCK1 && data_out == `DATA_UNLOCK1;
  wire u2 = flash_addr == `ADDR_UNLOCK2 && data_out == `DATA_UNLOCK2;
  wire dp = mode == 3 ? 1'b0 : mode == 4 ? 1'b1 : ~pd[7];
  wire [7:0] st = {dp, t1, tl, 1'b0, mode >= 3, t2, 2'b00};
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(data_in) if (rd) last = data_in;
  // no pull on the data bus: released lines show the inverse
  assign data_in = rd ? (mode == 0 ? mem[flash_addr[3:0]] : st) : ~last;
  assign ready_busy_out = !(mode inside {1, 2, 3});
  // commands latch when the write strobe or select rises
  always @(negedge wr) begin
    if (data_out == `DATA_RESET && mode != 3) begin
      mode = 0;
      tl = 1'b0;
      step = 0;
    end else if (mode == 3 && data_out == `DATA_SUSPEND) begin
      mode = 4;
    end else if (mode == 2 && data_out == `DATA_SECTOR_ERASE) begin
      es[flash_addr[21:16]] = 1'b1;
      cnt = WIN_RD;
    end else if (mode == 0) begin
      case (step)
        0, 3: step = u1 ? step + 1 : 0;
        1, 4: step = u2 ? step + 1 : 0;
        2: step = data_out == `DATA_PROGRAM ? 6 :
          data_out == `DATA_ERASE_SETUP ? 3 : 0;
        5: begin
          step = 0;
          if (data_out == `DATA_SECTOR_ERASE) begin
            mode = 2;
            es = 64'h0;
            es[flash_addr[21:16]] = 1'b1;
            cnt = WIN_RD;
            pd = 8'hFF;
            bad = 1'b0;
          end
        end
        default: begin
          step = 0;
          mode = 1;
          pa = flash_addr[3:0];
          pd = data_out;
          cnt = OP_RD;
          bad = |(data_out & ~mem[flash_addr[3:0]]);
        end
      endcase
    end
  end
  always @(negedge rd) begin
    if (mode inside {1, 2, 3}) t1 = ~t1;
    if (mode >= 2 && es[flash_addr[21:16]]) t2 = ~t2;
    if (mode inside {1, 2, 3}) begin
      if (cnt > 0) cnt--;
      else if (mode == 2) begin
        mode = 3;
        cnt = OP_RD;
      end else if (bad) tl = 1'b1;
      else begin
        mem[pa] = pd;
        mode = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/flash_status_props.sv ====
`include "flash_status_defs.svh"
`default_nettype none
module flash_status_props (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // user side
  input wire logic op_valid,
  input wire logic op_ready,
  input wire flash_status_pkg::op_t op_kind,
  input wire logic [21:0] op_addr,
  input wire logic result_valid,
  input wire flash_status_pkg::result_t result_code,
  input wire logic [7:0] last_status,
  // flash pins
  input wire logic [21:0] flash_addr,
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_wr;
  logic [21:0] held_addr;
  logic susp_q;
  logic add_q;
  logic [3:0] rds;
  wire fin = result_valid && result_code == flash_status_pkg::RESULT_FAIL;
  wire rej = result_valid && result_code == flash_status_pkg::RESULT_REJECTED;
  wire ok_res = result_valid && (result_code == flash_status_pkg::RESULT_DONE
    || result_code == flash_status_pkg::RESULT_SUSPENDED);
  // ====================
  // helpers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) last_wr <= 8'h00;
    else if (!write_strobe_n) last_wr <= data_out;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      held_addr <= 22'h000000;
      susp_q <= 1'b0;
      add_q <= 1'b0;
    end else if (op_valid && op_ready) begin
      held_addr <= op_addr;
      susp_q <= op_kind == flash_status_pkg::OP_SUSPEND;
      add_q <= op_kind == flash_status_pkg::OP_ADD_SECTOR;
    end
  end
  // reads since the last write, so a verdict can be traced to a pair
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) rds <= 4'h0;
    else if (!write_strobe_n) rds <= 4'h0;
    else if ($fell(output_strobe_n) && rds != 4'hF) rds <= rds + 4'h1;
  end
  // ====================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_rd; !output_strobe_n[*4] ##1 output_strobe_n; endsequence
  property p_rd_len; $fell(output_strobe_n) |-> s_rd; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  property p_rd_cs; !output_strobe_n |-> !chip_select_n && write_strobe_n;
  endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read select");
  property p_wr_cs; !write_strobe_n |-> !chip_select_n && data_oe; endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("write select");
  property p_rd_addr;
    $fell(output_strobe_n) && !susp_q |-> flash_addr == held_addr;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("poll address");
  property p_fail_cmd; fin |-> last_wr == `DATA_RESET; endproperty
  a_fail_cmd: assert property (p_fail_cmd) else $error("no reset");
  property p_fail_flag; fin |-> last_status[`BIT_TIME_LIMIT]; endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("fail flag");
  // an added sector verdict rests on one flag read after its write
  property p_pair; ok_res && !add_q |-> rds >= 4'h2; endproperty
  a_pair: assert property (p_pair) else $error("single read");
  property p_reject; rej |-> last_status[`BIT_ERASE_WIN]; endproperty
  a_reject: assert property (p_reject) else $error("bad reject");
  // two sync flops plus the report cycle
  property p_rb; result_valid && !rej |-> $past(ready_busy_out, 3); endproperty
  a_rb: assert property (p_rb) else $error("result while busy");
endmodule
bind flash_status_host flash_status_props flash_status_props_inst (
  .clock, .sys_rst, .op_valid, .op_ready, .op_kind, .op_addr,
  .result_valid, .result_code, .last_status, .flash_addr, .chip_select_n,
  .output_strobe_n, .write_strobe_n, .data_out, .data_oe, .ready_busy_out
);
`default_nettype wire

// ==== verif/test_flash_status_host.sv ====
`default_nettype none
module test_flash_status_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  flash_status_pkg::op_t op_kind = flash_status_pkg::OP_PROGRAM;
  logic [21:0] op_addr = 22'h000000;
  logic [7:0] op_data = 8'h00;
  logic op_ready, result_valid, erase_started, sector_erasing, data_oe;
  flash_status_pkg::result_t result_code;
  logic [7:0] last_status, data_in, data_out;
  logic [21:0] flash_addr;
  logic chip_select_n, output_strobe_n, write_strobe_n, ready_busy_out;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  flash_status_host flash_status_host_inst (
    .clock, .sys_rst, .op_valid, .op_kind, .op_addr, .op_data, .op_ready,
    .result_valid, .result_code, .erase_started, .sector_erasing,
    .last_status, .flash_addr, .chip_select_n, .output_strobe_n,
    .write_strobe_n, .data_in, .data_out, .data_oe, .ready_busy_out
  );
  flash_dev_model flash_dev_model_inst (
    .flash_addr, .chip_select_n, .output_strobe_n, .write_strobe_n,
    .data_out, .data_in, .ready_busy_out
  );
  // ====================
  // shared tasks
  task automatic chk(input string what, input logic [7:0] e, got);
    n_compared++;
    if (got !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic run_op(input flash_status_pkg::op_t k,
    input logic [21:0] a, input logic [7:0] d,
    input flash_status_pkg::result_t e);
    int n;
    @(negedge clock);
    while (op_ready !== 1'b1) @(negedge clock);
    op_valid = 1'b1;
    op_kind = k;
    op_addr = a;
    op_data = d;
    @(negedge clock);
    op_valid = 1'b0;
    n = 0;
    while (result_valid !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    chk("result_valid", 8'h01, {7'h00, result_valid});
    chk("result_code", {6'h00, e}, {6'h00, result_code});
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_program;
    run_op(flash_status_pkg::OP_PROGRAM, 22'h000001, 8'h5A,
      flash_status_pkg::RESULT_DONE);
    chk("program data", 8'h5A, last_status);
    $display("test program finished");
  endtask
  task automatic t_overprogram;
    run_op(flash_status_pkg::OP_PROGRAM, 22'h000001, 8'hA5,
      flash_status_pkg::RESULT_FAIL);
    chk("limit flag", 8'h20, last_status & 8'h20);
    // only a device that took the reset command accepts this one
    run_op(flash_status_pkg::OP_PROGRAM, 22'h000002, 8'h00,
      flash_status_pkg::RESULT_DONE);
    chk("after reset", 8'h00, last_status);
    $display("test overprogram finished");
  endtask
  task automatic t_erase;
    run_op(flash_status_pkg::OP_SECTOR_ERASE, 22'h050000, 8'h00,
      flash_status_pkg::RESULT_DONE);
    chk("erased data", 8'hFF, last_status);
    chk("sector_erasing", 8'h00, {7'h00, sector_erasing});
    $display("test erase finished");
  endtask
  task automatic t_add;
    run_op(flash_status_pkg::OP_ADD_SECTOR, 22'h060000, 8'h00,
      flash_status_pkg::RESULT_REJECTED);
    chk("erase_started", 8'h01, {7'h00, erase_started});
    $display("test added sector finished");
  endtask
  task automatic t_suspend;
    run_op(flash_status_pkg::OP_SUSPEND, 22'h050000, 8'h00,
      flash_status_pkg::RESULT_SUSPENDED);
    // no erase is pending here, so no sector can show as erasing
    chk("idle sector", 8'h00, {7'h00, sector_erasing});
    $display("test suspend finished");
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    t_program();
    t_overprogram();
    t_erase();
    t_add();
    t_suspend();
    close_out();
  end
endmodule
`default_nettype wire
